// [smr_pkg.sv]
package smr_pkg;
   // Slave addresses
   localparam logic [6:0] ADDR_FIXED = 7'h2e;
   localparam logic [6:0] ADDR_SEL_LO = 7'h2c;
   localparam logic [6:0] ADDR_SEL_HI = 7'h2d;
   // Bits per byte before the acknowledge slot
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam int REG_COUNT = 256;

   typedef enum logic [2:0] {
      SM_IDLE,
      SM_ADDR,
      SM_WR,
      SM_RD,
      SM_SKIP
   } smr_state_t;

   // Register-file write request
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } smr_wr_t;
endpackage

// [smr_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser; the first flop feeds only the second
module smr_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Data
   input wire logic d_i,
   output logic q_o
);
   logic meta_r;
   logic sync_r;

   // Reset to released-bus level
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end

   assign q_o = sync_r;
endmodule // smr_sync

// [smr_slave.sv]
`timescale 1ns/1ps
// Summary of operation
// - Fixed variant answers address 0101110 only
// - Straps sampled once after power-up reset
// - Select mode: input low 2C, high 2D
// - Address latched at eighth rising clock edge
// - Nine clocks per byte, MSB first
// - Data changes only while clock low
// - Direction fixed until next start
// - Writes one or two bytes; reads one
// - First written byte loads address pointer
// - Second written byte goes to register
// - Pointer-only write leaves data untouched
// - Read returns register at current pointer
// - Read: address with bit 1, one byte
// - Send, receive and read byte supported
// - Repeated start begins fresh operation
module smr_slave (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Variant and straps
   input wire logic addr_fixed_i,
   input wire logic addr_mode_strap_i,
   input wire logic addr_sel_i,
   // Serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Register view
   output logic [7:0] pointer_o,
   output logic [6:0] slave_addr_o,
   output logic addr_locked_o
);
   logic scl_s;
   logic sda_s;
   logic scl_d_r;
   logic sda_d_r;
   smr_pkg::smr_state_t st_r, st_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [1:0] wcnt_r, wcnt_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic drv_r, drv_nxt;
   logic [6:0] addr_r, addr_nxt;
   logic lock_r, lock_nxt;
   logic strap_done_r, strap_done_nxt;
   logic [1:0] settle_r, settle_nxt;
   logic fixed_s, strap_s, sel_s;
   logic [6:0] sel_r, sel_nxt;
   logic rnw_r, rnw_nxt;
   smr_pkg::smr_wr_t wr;
   logic [7:0] regs_r [smr_pkg::REG_COUNT];
   logic scl_rise, scl_fall, start_c, stop_c;
   logic [7:0] byte_in;

   // Pins cross into the device clock domain
   smr_sync u_scl (.clk_i(clk_i), .rst_i(rst_i), .d_i(scl_i), .q_o(scl_s));
   smr_sync u_sda (.clk_i(clk_i), .rst_i(rst_i), .d_i(sda_i), .q_o(sda_s));
   // Straps are pins too; a raw read could catch a level mid-change
   smr_sync u_fixed (.clk_i(clk_i), .rst_i(rst_i), .d_i(addr_fixed_i), .q_o(fixed_s));
   smr_sync u_strap (.clk_i(clk_i), .rst_i(rst_i), .d_i(addr_mode_strap_i), .q_o(strap_s));
   smr_sync u_sel (.clk_i(clk_i), .rst_i(rst_i), .d_i(addr_sel_i), .q_o(sel_s));

   // Edge history of the synchronised pins
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // Bus events; a data edge while clock high frames the operation
   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign byte_in = {sh_r[6:0], sda_s};

   // Address selection and bit engine
   always_comb begin
      st_nxt = st_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      wcnt_nxt = wcnt_r;
      ptr_nxt = ptr_r;
      drv_nxt = drv_r;
      addr_nxt = addr_r;
      lock_nxt = lock_r;
      strap_done_nxt = strap_done_r | settle_r[1];
      settle_nxt = {settle_r[0], 1'b1};
      sel_nxt = sel_r;
      rnw_nxt = rnw_r;
      wr = '0;
      // Straps caught once, after the synchronisers have filled from reset
      if (!strap_done_r && settle_r[1]) begin
         if (fixed_s || strap_s) begin
            sel_nxt = smr_pkg::ADDR_FIXED;
         end else if (sel_s) begin
            sel_nxt = smr_pkg::ADDR_SEL_HI;
         end else begin
            sel_nxt = smr_pkg::ADDR_SEL_LO;
         end
         addr_nxt = sel_nxt;
      end
      if (start_c) begin
         // Fresh address byte after start or repeated start
         st_nxt = smr_pkg::SM_ADDR;
         bit_nxt = '0;
         drv_nxt = 1'b0;
         wcnt_nxt = '0;
      end else if (stop_c) begin
         st_nxt = smr_pkg::SM_IDLE;
         drv_nxt = 1'b0;
      end else if (st_r != smr_pkg::SM_IDLE && st_r != smr_pkg::SM_SKIP) begin
         if (scl_rise && bit_r < smr_pkg::BITS_PER_BYTE) begin
            sh_nxt = byte_in;
            // Eighth rising edge carries the direction bit
            if (st_r == smr_pkg::SM_ADDR && bit_r == smr_pkg::BITS_PER_BYTE - 4'h1 && !lock_r
                && sh_r[6:0] == addr_r) begin
               lock_nxt = 1'b1;
            end
         end
         if (scl_rise) begin
            bit_nxt = bit_r + 4'h1;
         end
         if (scl_fall) begin
            if (bit_r == smr_pkg::BITS_PER_BYTE) begin
               // Acknowledge slot driven while clock low
               drv_nxt = 1'b0;
               case (st_r)
                  smr_pkg::SM_ADDR: begin
                     if (sh_r[7:1] == addr_r) begin
                        drv_nxt = 1'b1;
                        rnw_nxt = sh_r[0];
                     end else begin
                        st_nxt = smr_pkg::SM_SKIP;
                     end
                  end
                  smr_pkg::SM_WR: begin
                     drv_nxt = (wcnt_r < 2'h2);
                     if (wcnt_r == 2'h0) begin
                        ptr_nxt = sh_r;
                     end else if (wcnt_r == 2'h1) begin
                        wr = '{we: 1'b1, addr: ptr_r, data: sh_r};
                     end
                     if (wcnt_r != 2'h3) begin
                        wcnt_nxt = wcnt_r + 2'h1;
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (bit_r == smr_pkg::BITS_PER_BYTE + 4'h1) begin
               // Ack clock finished: pick next byte phase
               bit_nxt = '0;
               drv_nxt = 1'b0;
               if (st_r == smr_pkg::SM_ADDR) begin
                  if (rnw_r) begin
                     st_nxt = smr_pkg::SM_RD;
                     sh_nxt = regs_r[ptr_r];
                     drv_nxt = ~regs_r[ptr_r][7];
                  end else begin
                     st_nxt = smr_pkg::SM_WR;
                  end
               end else if (st_r == smr_pkg::SM_RD) begin
                  st_nxt = smr_pkg::SM_SKIP;
               end
            end else if (st_r == smr_pkg::SM_RD) begin
               // Next read bit, MSB first, low drive only
               drv_nxt = ~sh_r[7];
            end
         end
      end
   end

   // Pointer-only writes never raise the write strobe
   always_ff @(posedge clk_i) begin
      if (wr.we) begin
         regs_r[wr.addr] <= wr.data;
      end
   end

   // Engine state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= smr_pkg::SM_IDLE;
         bit_r <= '0;
         sh_r <= smr_pkg::DATA_RESET;
         wcnt_r <= '0;
         ptr_r <= smr_pkg::PTR_RESET;
         drv_r <= 1'b0;
         addr_r <= smr_pkg::ADDR_FIXED;
         lock_r <= 1'b0;
         strap_done_r <= 1'b0;
         settle_r <= '0;
         sel_r <= smr_pkg::ADDR_FIXED;
         rnw_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         wcnt_r <= wcnt_nxt;
         ptr_r <= ptr_nxt;
         drv_r <= drv_nxt;
         addr_r <= addr_nxt;
         lock_r <= lock_nxt;
         strap_done_r <= strap_done_nxt;
         settle_r <= settle_nxt;
         sel_r <= sel_nxt;
         rnw_r <= rnw_nxt;
      end
   end

   // Open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_o = drv_r;
   assign pointer_o = ptr_r;
   assign slave_addr_o = addr_r;
   assign addr_locked_o = lock_r;

   property p_addr_stable;
      @(posedge clk_i) disable iff (rst_i) strap_done_r |=> $stable(addr_r);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address changed after strap");

   property p_fixed_addr;
      @(posedge clk_i) disable iff (rst_i)
         (!strap_done_r && settle_r[1] && fixed_s) |=> addr_r == smr_pkg::ADDR_FIXED;
   endproperty
   a_fixed_addr: assert property (p_fixed_addr) else $error("fixed variant wrong address");

   property p_lock_sticky;
      @(posedge clk_i) disable iff (rst_i) lock_r |=> lock_r;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("address lock dropped");

   property p_drive_clock_low;
      @(posedge clk_i) disable iff (rst_i) (scl_s && scl_d_r && !start_c && !stop_c) |=> $stable(drv_r);
   endproperty
   a_drive_clock_low: assert property (p_drive_clock_low) else $error("data changed while clock high");

   property p_ack_write;
      @(posedge clk_i) disable iff (rst_i)
         (st_r == smr_pkg::SM_WR && scl_fall && bit_r == 4'h8 && wcnt_r < 2'h2 && !start_c && !stop_c) |=> drv_r;
   endproperty
   a_ack_write: assert property (p_ack_write) else $error("write byte not acknowledged");

   property p_pointer_load;
      @(posedge clk_i) disable iff (rst_i)
         (st_r == smr_pkg::SM_WR && scl_fall && bit_r == 4'h8 && wcnt_r == 2'h0 && !start_c && !stop_c)
         |=> ptr_r == $past(sh_r);
   endproperty
   a_pointer_load: assert property (p_pointer_load) else $error("pointer not loaded");

   property p_ptr_hold;
      @(posedge clk_i) disable iff (rst_i) (st_r != smr_pkg::SM_WR) |=> $stable(ptr_r);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed outside write");

   property p_start_fresh;
      @(posedge clk_i) disable iff (rst_i) start_c |=> (st_r == smr_pkg::SM_ADDR && bit_r == 4'h0 && !drv_r);
   endproperty
   a_start_fresh: assert property (p_start_fresh) else $error("start not fresh");

   property p_no_ack_mismatch;
      @(posedge clk_i) disable iff (rst_i) (st_r == smr_pkg::SM_SKIP) |-> !drv_r;
   endproperty
   a_no_ack_mismatch: assert property (p_no_ack_mismatch) else $error("drove bus when unaddressed");
endmodule // smr_slave

// [smr_host_model.sv]
`timescale 1ns/1ps
// Bus master model: clock idles high, data is open drain with a pull-up
module smr_host_model (
   // Clock
   input wire logic clk_i,
   // Bus pins
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // Quarter of the 200 ns bus period
   task automatic qtr();
      repeat (2) @(posedge clk_i);
   endtask
   // Start or repeated start; long low gives the slave time to let go
   task automatic start();
      sda_oe_o <= 1'b0;
      repeat (3) qtr();
      scl_o <= 1'b1;
      qtr();
      sda_oe_o <= 1'b1;
      qtr();
      scl_o <= 1'b0;
   endtask
   // Nine pulses MSB first; v[0] high leaves the ninth bit released
   task automatic byte9(input logic [8:0] v, output logic [8:0] s);
      for (int i = 8; i >= 0; i--) begin
         qtr();
         sda_oe_o <= ~v[i];
         qtr();
         scl_o <= 1'b1;
         qtr();
         s[i] = sda_i;
         qtr();
         scl_o <= 1'b0;
      end
   endtask
   // Data low while clock low, then rises with clock high
   task automatic stop();
      qtr();
      sda_oe_o <= 1'b1;
      qtr();
      scl_o <= 1'b1;
      qtr();
      sda_oe_o <= 1'b0;
      qtr();
   endtask
endmodule // smr_host_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] pins = 3'h4;
   logic scl, host_oe, sda_o, sda_oe_o, addr_locked_o;
   logic [7:0] pointer_o;
   logic [6:0] slave_addr_o;
   wire sda = ~host_oe & (~sda_oe_o | sda_o); // Pull-up wins when nobody pulls
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [31:0] rnd = 32'h3712;
   always #12.5 clk_i = ~clk_i;
   smr_slave smr_slave_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_fixed_i(pins[2]),
      .addr_mode_strap_i(pins[1]), .addr_sel_i(pins[0]), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pointer_o(pointer_o),
      .slave_addr_o(slave_addr_o), .addr_locked_o(addr_locked_o));
   smr_host_model smr_host_model_inst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
   // Expected address from the strap pattern
   function automatic logic [6:0] exp_addr(input logic [2:0] c);
      if (c[2] | c[1])
         return smr_pkg::ADDR_FIXED;
      return c[0] ? smr_pkg::ADDR_SEL_HI : smr_pkg::ADDR_SEL_LO;
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic conclude();
      if (err_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Write one byte and check the slave's answer in the ninth bit
   task automatic wr(input logic [7:0] b, input logic nack);
      logic [8:0] s;
      smr_host_model_inst.byte9({b, 1'b1}, s);
      chk("ack", {7'h00, s[0]}, {7'h00, nack});
   endtask
   // Address with direction 1, one byte back, then no-acknowledge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [8:0] s;
      wr(a | 8'h01, 1'b0);
      smr_host_model_inst.byte9(9'h1ff, s);
      chk("rdata", s[8:1], e);
   endtask
   // Hang guard; the whole run needs about 7200 cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      logic [2:0] cfg [5];
      logic [7:0] a, p, p2, d, d2;
      cfg = '{3'h4, 3'h5, 3'h2, 3'h0, 3'h1};
      for (int k = 0; k < 5; k++) begin
         rst_i <= 1'b1;
         pins <= cfg[k];
         repeat (3) @(posedge clk_i);
         rst_i <= 1'b0;
         repeat (4) @(posedge clk_i);
         pins <= ~cfg[k];
         repeat (2) @(posedge clk_i);
         a = {exp_addr(cfg[k]), 1'b0};
         chk("addr", {1'b0, slave_addr_o}, a >> 1);
         chk("sda_o", {7'h00, sda_o}, 8'h00);
         rnd = xs(rnd);
         p = (k == 0) ? 8'hff : rnd[7:0];
         d = (k == 1) ? 8'h00 : rnd[15:8];
         d2 = rnd[23:16];
         p2 = p ^ 8'h5a;
         // Neighbouring address must be ignored
         smr_host_model_inst.start();
         wr(a ^ 8'h02, 1'b1);
         smr_host_model_inst.stop();
         chk("locked", {7'h00, addr_locked_o}, 8'h00);
         smr_host_model_inst.start();
         wr(a, 1'b0);
         wr(p, 1'b0);
         wr(d, 1'b0);
         smr_host_model_inst.stop();
         chk("ptr", pointer_o, p);
         chk("locked", {7'h00, addr_locked_o}, 8'h01);
         // Third byte is refused
         smr_host_model_inst.start();
         wr(a, 1'b0);
         wr(p2, 1'b0);
         wr(d2, 1'b0);
         wr(~d2, 1'b1);
         smr_host_model_inst.stop();
         // Pointer-only write, repeated start, read
         smr_host_model_inst.start();
         wr(a, 1'b0);
         wr(p, 1'b0);
         smr_host_model_inst.start();
         rd(a, d);
         smr_host_model_inst.stop();
         chk("ptr", pointer_o, p);
         smr_host_model_inst.start();
         rd(a, d);
         smr_host_model_inst.stop();
         smr_host_model_inst.start();
         wr(a, 1'b0);
         wr(p2, 1'b0);
         smr_host_model_inst.stop();
         smr_host_model_inst.start();
         rd(a, d2);
         smr_host_model_inst.stop();
      end
      conclude();
   end
endmodule // tb_top
